// file: hw/hbac_pkg.sv
// package for the hex/bcd/ascii conversion datapath
// assumes a single 50 MHz clock domain shared with the scan engine
package hbac_pkg;
    // ----------------------------------------------------------------
    // operations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        HBAC_OP_HEX_TO_ASCII = 2'h0,
        HBAC_OP_ASCII_TO_HEX = 2'h1,
        HBAC_OP_BCD_TO_ASCII = 2'h2,
        HBAC_OP_NONE = 2'h3
    } hbac_op_t;

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        HBAC_ST_IDLE = 2'h0,
        HBAC_ST_READ = 2'h1,
        HBAC_ST_CONV = 2'h2,
        HBAC_ST_WRITE = 2'h3
    } hbac_state_t;

    // ----------------------------------------------------------------
    // figures
    // ----------------------------------------------------------------
    localparam logic [15:0] HBAC_HEX_MAX_DIGITS = 16'h0004;
    localparam logic [15:0] HBAC_BCD_MAX_DIGITS = 16'h0005;
    localparam logic [15:0] HBAC_MIN_DIGITS = 16'h0001;
    localparam logic [7:0] HBAC_ASCII_ZERO = 8'h30;
    localparam logic [7:0] HBAC_ASCII_NINE = 8'h39;
    localparam logic [7:0] HBAC_ASCII_UPPER_A = 8'h41;
    localparam logic [7:0] HBAC_ASCII_UPPER_F = 8'h46;
    localparam logic [7:0] HBAC_LETTER_BIAS = 8'h37;
    localparam logic [3:0] HBAC_TEN = 4'hA;
    localparam int HBAC_BIT_POINTS = 16;
    localparam int HBAC_BCD_BITS = 20;
    localparam logic [2:0] HBAC_SLOT_LAST = 3'h4;
endpackage

// file: hw/hbac_converter.sv
// hex to ascii, ascii to hex, and binary to bcd to ascii datapath
// assumes the scan engine pulses start_i once per scan while the rung is on,
// and that operand storage answers a read in the cycle after the request
`timescale 1ns/1ns

module hbac_converter
    import hbac_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // scan engine command
    input wire logic start_i,
    input wire logic enable_i,
    input wire logic [1:0] op_i,
    input wire logic [15:0] first_source_operand_i,
    input wire logic [15:0] digit_count_operand_i,
    input wire logic src_is_timer_i,
    input wire logic cnt_is_timer_i,
    input wire logic dst_is_timer_i,
    input wire logic src_is_bit_i,
    input wire logic dst_is_bit_i,
    // operand storage
    output logic src_rd_o,
    output logic [2:0] src_index_o,
    output logic src_bit_mode_o,
    input wire logic [15:0] src_word_i,
    output logic dst_wr_o,
    output logic [2:0] dst_index_o,
    output logic dst_bit_mode_o,
    output logic dst_preset_o,
    output logic [15:0] result_operand_o,
    // status
    output logic busy_o,
    output logic done_o,
    output logic program_error_flag_o,
    output logic error_led_o
);
    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    hbac_state_t state_q, state_d;
    hbac_op_t op_q;
    logic [15:0] bin_q;
    logic [2:0] count_q;
    logic [2:0] slot_q;
    logic [15:0] acc_q;
    logic [HBAC_BCD_BITS-1:0] bcd_q;
    logic err_q;
    logic [15:0] max_digits;
    logic count_ok;
    logic [7:0] chr;
    logic chr_digit;
    logic chr_letter;
    logic chr_ok;
    logic [3:0] chr_nib;
    logic [2:0] sel_digit;
    logic [3:0] out_nib;
    logic [7:0] out_chr;
    logic last_slot;
    logic [HBAC_BCD_BITS-1:0] bcd_calc;
    hbac_op_t op_in;

    assign op_in = hbac_op_t'(op_i);
    assign max_digits = (op_in == HBAC_OP_BCD_TO_ASCII) ? HBAC_BCD_MAX_DIGITS
                                                       : HBAC_HEX_MAX_DIGITS;
    // (count already the current value if timer)
    assign count_ok = (digit_count_operand_i >= HBAC_MIN_DIGITS)
                      && (digit_count_operand_i <= max_digits);
    assign chr = src_word_i[7:0];
    assign chr_digit = (chr >= HBAC_ASCII_ZERO) && (chr <= HBAC_ASCII_NINE);
    assign chr_letter = (chr >= HBAC_ASCII_UPPER_A) && (chr <= HBAC_ASCII_UPPER_F);
    assign chr_ok = (src_word_i[15:8] == 8'h00) && (chr_digit || chr_letter);
    assign chr_nib = chr_digit ? 4'(chr - HBAC_ASCII_ZERO) : 4'(chr - HBAC_LETTER_BIAS);
    // msd at first destination slot
    assign sel_digit = 3'(count_q - slot_q - 3'h1);
    assign out_nib = (op_q == HBAC_OP_BCD_TO_ASCII) ? bcd_q[sel_digit*4 +: 4]
                                                    : bin_q[sel_digit[1:0]*4 +: 4];
    assign out_chr = (out_nib < HBAC_TEN) ? 8'(HBAC_ASCII_ZERO + {4'h0, out_nib})
                                          : 8'(HBAC_LETTER_BIAS + {4'h0, out_nib});
    assign last_slot = (slot_q == 3'(count_q - 3'h1));

    // ----------------------------------------------------------------
    // binary to bcd, shift and add three
    // ----------------------------------------------------------------
    always_comb begin
        bcd_calc = '0;
        for (int i = 15; i >= 0; i--) begin
            for (int d = 0; d < 5; d++) begin
                if (bcd_calc[d*4 +: 4] > 4'h4) begin
                    bcd_calc[d*4 +: 4] = 4'(bcd_calc[d*4 +: 4] + 4'h3);
                end
            end
            bcd_calc = {bcd_calc[HBAC_BCD_BITS-2:0], bin_q[i]};
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            HBAC_ST_IDLE: begin
                if (start_i && enable_i && op_in != HBAC_OP_NONE) begin
                    if (!count_ok) begin
                        state_d = HBAC_ST_IDLE;
                    end else if (op_in == HBAC_OP_ASCII_TO_HEX) begin
                        state_d = HBAC_ST_READ;
                    end else begin
                        state_d = HBAC_ST_CONV;
                    end
                end
            end
            HBAC_ST_READ: begin
                if (!chr_ok) begin
                    state_d = HBAC_ST_IDLE;
                end else if (last_slot) begin
                    state_d = HBAC_ST_WRITE;
                end
            end
            HBAC_ST_CONV: begin
                state_d = HBAC_ST_WRITE;
            end
            HBAC_ST_WRITE: begin
                if (op_q == HBAC_OP_ASCII_TO_HEX || last_slot) begin
                    state_d = HBAC_ST_IDLE;
                end
            end
            default: begin
                state_d = HBAC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= HBAC_ST_IDLE;
            op_q <= HBAC_OP_NONE;
            bin_q <= '0;
            count_q <= '0;
            slot_q <= '0;
            acc_q <= '0;
            bcd_q <= '0;
            err_q <= 1'b0;
        end else begin
            state_q <= state_d;
            case (state_q)
                HBAC_ST_IDLE: begin
                    slot_q <= '0;
                    acc_q <= '0;
                    if (start_i && enable_i && op_in != HBAC_OP_NONE) begin
                        op_q <= op_in;
                        bin_q <= first_source_operand_i;
                        count_q <= digit_count_operand_i[2:0];
                        err_q <= !count_ok;
                    end
                end
                HBAC_ST_READ: begin
                    acc_q <= {acc_q[11:0], chr_nib};
                    slot_q <= 3'(slot_q + 3'h1);
                    if (!chr_ok) begin
                        err_q <= 1'b1;
                    end
                    if (last_slot) begin
                        slot_q <= '0;
                    end
                end
                HBAC_ST_CONV: begin
                    bcd_q <= bcd_calc;
                end
                HBAC_ST_WRITE: begin
                    slot_q <= (slot_q == HBAC_SLOT_LAST) ? '0 : 3'(slot_q + 3'h1);
                end
                default: begin
                    slot_q <= '0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // storage port
    // ----------------------------------------------------------------
    logic [15:0] result_d;
    logic done_d;
    logic [15:0] result_q;
    logic done_q;
    logic wr_q;
    logic [2:0] widx_q;
    logic wpre_q;
    logic rd_q;
    logic [2:0] ridx_q;

    assign result_d = (op_q == HBAC_OP_ASCII_TO_HEX) ? acc_q : {8'h00, out_chr};
    assign done_d = ((state_q == HBAC_ST_WRITE) && (state_d == HBAC_ST_IDLE))
                    || ((state_q != HBAC_ST_IDLE) && (state_d == HBAC_ST_IDLE) && err_q)
                    || ((state_q == HBAC_ST_READ) && !chr_ok)
                    || ((state_q == HBAC_ST_IDLE) && start_i && enable_i
                        && op_in != HBAC_OP_NONE && !count_ok);

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            result_q <= '0;
            wr_q <= 1'b0;
            widx_q <= '0;
            wpre_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            wr_q <= (state_q == HBAC_ST_WRITE);
            widx_q <= slot_q;
            // preset flag only rides with the write pulse
            wpre_q <= (state_q == HBAC_ST_WRITE) && dst_is_timer_i
                      && (op_q == HBAC_OP_ASCII_TO_HEX);
            result_q <= result_d;
            done_q <= done_d;
        end
    end

    // first read issued from idle so data is back in read state
    always_comb begin
        rd_q = 1'b0;
        ridx_q = slot_q;
        if (state_q == HBAC_ST_IDLE) begin
            rd_q = start_i && enable_i && (op_in == HBAC_OP_ASCII_TO_HEX) && count_ok;
            ridx_q = '0;
        end else if (state_q == HBAC_ST_READ) begin
            rd_q = chr_ok && !last_slot;
            ridx_q = 3'(slot_q + 3'h1);
        end
    end

    assign src_rd_o = rd_q;
    assign src_index_o = ridx_q;
    assign src_bit_mode_o = src_is_bit_i;
    assign dst_wr_o = wr_q;
    assign dst_index_o = widx_q;
    assign dst_bit_mode_o = dst_is_bit_i;
    assign dst_preset_o = wpre_q;
    assign result_operand_o = result_q;
    assign busy_o = (state_q != HBAC_ST_IDLE);
    assign done_o = done_q;
    assign program_error_flag_o = err_q;
    assign error_led_o = err_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // msd of the selected hex digits, from the held operands
    logic [3:0] msd_nib;
    logic [7:0] msd_chr;
    assign msd_nib = 4'(bin_q >> {3'(count_q - 3'h1), 2'h0});
    assign msd_chr = (msd_nib < HBAC_TEN)
                     ? 8'(HBAC_ASCII_ZERO + {4'h0, msd_nib})
                     : 8'(HBAC_ASCII_UPPER_A + {4'h0, 4'(msd_nib - HBAC_TEN)});
    chk_bad_count_err: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (state_q == HBAC_ST_IDLE && start_i && enable_i && op_in != HBAC_OP_NONE && !count_ok)
        |=> (err_q && state_q == HBAC_ST_IDLE))
        else $error("bad digit count did not raise error");
    chk_hex_digit_range: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (state_q == HBAC_ST_CONV && op_q == HBAC_OP_HEX_TO_ASCII)
        |-> (count_q >= 3'h1 && count_q <= 3'h4))
        else $error("hex conversion with illegal count");
    chk_bcd_digit_range: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (state_q == HBAC_ST_CONV) |-> (count_q >= 3'h1 && count_q <= 3'h5))
        else $error("bcd conversion with illegal count");
    chk_bad_char_err: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (state_q == HBAC_ST_READ && !chr_ok) |=> (err_q && state_q == HBAC_ST_IDLE && !wr_q))
        else $error("bad character not flagged");
    chk_ascii_upper_zero: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (dst_wr_o && op_q != HBAC_OP_ASCII_TO_HEX) |-> (result_operand_o[15:8] == 8'h00))
        else $error("ascii word upper byte not zero");
    chk_first_is_msd: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (state_q == HBAC_ST_WRITE && op_q == HBAC_OP_HEX_TO_ASCII && slot_q == 3'h0)
        |=> (dst_wr_o && dst_index_o == 3'h0 && result_operand_o == {8'h00, msd_chr}))
        else $error("first slot is not most significant digit");
    chk_rescan_runs: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (state_q == HBAC_ST_IDLE && start_i && enable_i && count_ok && op_in != HBAC_OP_NONE)
        |=> busy_o)
        else $error("enabled scan did not start conversion");
    chk_preset_write: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (dst_preset_o) |-> (dst_wr_o && op_q == HBAC_OP_ASCII_TO_HEX))
        else $error("preset write outside ascii to hex");
    chk_hex_pack: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (state_q == HBAC_ST_READ && chr_ok) |=> (acc_q[3:0] == $past(chr_nib)))
        else $error("character not packed into result");
endmodule

// file: testbench/hbac_storage_model.sv
// operand storage model for the conversion datapath
// assumes reads are answered one cycle after the request
`timescale 1ns/1ns
module hbac_storage_model (
    // clock
    input wire logic mclk_i,
    // source side
    input wire logic src_rd_i,
    input wire logic [2:0] src_index_i,
    output logic [15:0] src_word_o,
    // destination side
    input wire logic dst_wr_i,
    input wire logic [2:0] dst_index_i,
    input wire logic dst_preset_i,
    input wire logic [15:0] data_i
);
    logic [15:0] src_mem [0:7];
    logic [15:0] dst_mem [0:7];
    logic preset_seen;
    int wr_count;
    initial begin
        src_word_o = 16'h0000;
        preset_seen = 1'b0;
        wr_count = 0;
    end
    always @(posedge mclk_i) begin
        // word read one cycle after request, junk otherwise
        if (src_rd_i) begin
            src_word_o <= src_mem[src_index_i];
        end else begin
            src_word_o <= ~src_word_o;
        end
        if (dst_wr_i) begin
            dst_mem[dst_index_i] <= data_i;
            preset_seen <= dst_preset_i;
            wr_count <= wr_count + 1;
        end
    end
endmodule

// file: testbench/hbac_converter_tb.sv
// self-checking bench for the conversion datapath
// assumes the storage model sits on the operand storage ports
`timescale 1ns/1ns
module hbac_converter_tb;
    import hbac_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic start_i = 1'b0;
    logic enable_i = 1'b1;
    logic [1:0] op_i = 2'h3;
    logic [15:0] first_source_operand_i = 16'h0000;
    logic [15:0] digit_count_operand_i = 16'h0000;
    logic src_is_timer_i = 1'b0;
    logic cnt_is_timer_i = 1'b1;
    logic dst_is_timer_i = 1'b0;
    logic src_is_bit_i = 1'b0;
    logic dst_is_bit_i = 1'b0;
    logic src_rd_o, src_bit_mode_o, dst_wr_o, dst_bit_mode_o, dst_preset_o;
    logic busy_o, done_o, program_error_flag_o, error_led_o;
    logic [2:0] src_index_o, dst_index_o;
    logic [15:0] src_word_i, result_operand_o;
    int mismatches = 0;
    int cmp_count = 0;
    hbac_converter dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .start_i(start_i),
        .enable_i(enable_i), .op_i(op_i), .first_source_operand_i(first_source_operand_i),
        .digit_count_operand_i(digit_count_operand_i), .src_is_timer_i(src_is_timer_i),
        .cnt_is_timer_i(cnt_is_timer_i), .dst_is_timer_i(dst_is_timer_i),
        .src_is_bit_i(src_is_bit_i), .dst_is_bit_i(dst_is_bit_i), .src_rd_o(src_rd_o),
        .src_index_o(src_index_o), .src_bit_mode_o(src_bit_mode_o), .src_word_i(src_word_i),
        .dst_wr_o(dst_wr_o), .dst_index_o(dst_index_o), .dst_bit_mode_o(dst_bit_mode_o),
        .dst_preset_o(dst_preset_o), .result_operand_o(result_operand_o), .busy_o(busy_o),
        .done_o(done_o), .program_error_flag_o(program_error_flag_o), .error_led_o(error_led_o));
    hbac_storage_model mdl (.mclk_i(mclk_i), .src_rd_i(src_rd_o), .src_index_i(src_index_o),
        .src_word_o(src_word_i), .dst_wr_i(dst_wr_o), .dst_index_i(dst_index_o),
        .dst_preset_i(dst_preset_o), .data_i(result_operand_o));
    initial begin
        forever #10 mclk_i = ~mclk_i;
    end
    // ------------------------------------------------------------
    // compare helpers
    // ------------------------------------------------------------
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t word got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_word({15'h0000, got}, {15'h0000, exp});
    endtask
    function automatic logic [15:0] hex_char(input logic [3:0] nib);
        return {8'h00, (nib < 4'hA) ? 8'h30 + nib : 8'h37 + nib};
    endfunction
    // one scan; lat below zero skips the latency check
    task automatic run(input logic [1:0] op, input logic [15:0] src, input logic [15:0] cnt,
                       input logic err, input int lat, input int wr);
        int n;
        int wr_base;
        wr_base = mdl.wr_count;
        for (int i = 0; i < 8; i++) mdl.dst_mem[i] = 16'hFFFF;
        @(negedge mclk_i);
        op_i = op;
        first_source_operand_i = src;
        digit_count_operand_i = cnt;
        start_i = 1'b1;
        @(negedge mclk_i);
        start_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 40) begin
            @(negedge mclk_i);
            n++;
        end
        if (lat >= 0) check_word(16'(n), 16'(lat));
        check_bit(program_error_flag_o, err);
        check_bit(error_led_o, err);
        @(negedge mclk_i);
        check_word(16'(mdl.wr_count - wr_base), 16'(wr));
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_hex;
        for (int n = 1; n <= 4; n++) begin
            run(2'h0, 16'hA9F3, 16'(n), 1'b0, n + 1, n);
            for (int i = 0; i < n; i++)
                check_word(mdl.dst_mem[i], hex_char(4'(16'hA9F3 >> (4 * (n - 1 - i)))));
        end
        $display("hex to ascii done");
    endtask
    task automatic t_bcd;
        int v;
        for (int k = 0; k < 2; k++) begin
            v = (k == 0) ? 12345 : 65535;
            for (int n = 1; n <= 5; n++) begin
                run(2'h2, 16'(v), 16'(n), 1'b0, n + 1, n);
                for (int i = 0; i < n; i++)
                    check_word(mdl.dst_mem[i], {12'h003, 4'((v / (10 ** (n - 1 - i))) % 10)});
            end
        end
        $display("bcd to ascii done");
    endtask
    task automatic t_ascii_to_hex_op;
        mdl.src_mem[0] = 16'h0031;
        mdl.src_mem[1] = 16'h0041;
        mdl.src_mem[2] = 16'h0032;
        mdl.src_mem[3] = 16'h0046;
        dst_is_timer_i = 1'b1;
        for (int n = 1; n <= 4; n++) begin
            run(2'h1, 16'h0000, 16'(n), 1'b0, n + 1, 1);
            check_word(mdl.dst_mem[0], 16'h1A2F >> (4 * (4 - n)));
            check_bit(mdl.preset_seen, 1'b1);
        end
        dst_is_timer_i = 1'b0;
        $display("ascii to hex done");
    endtask
    task automatic t_bad;
        logic [15:0] bad_chr [6] = '{16'h002F, 16'h003A, 16'h0040, 16'h0047, 16'h0061, 16'h0131};
        logic [17:0] bad_cnt [7] = '{{2'h0, 16'h0000}, {2'h0, 16'h0005}, {2'h1, 16'h0000},
            {2'h1, 16'h0005}, {2'h2, 16'h0000}, {2'h2, 16'h0006}, {2'h0, 16'h8001}};
        foreach (bad_cnt[i]) run(bad_cnt[i][17:16], 16'h1234, bad_cnt[i][15:0], 1'b1, 0, 0);
        mdl.src_mem[0] = 16'h0039;
        foreach (bad_chr[i]) begin
            mdl.src_mem[1] = bad_chr[i];
            run(2'h1, 16'h0000, 16'h0002, 1'b1, -1, 0);
        end
        $display("error cases done");
    endtask
    task automatic t_enable_low;
        int wr_base;
        wr_base = mdl.wr_count;
        @(negedge mclk_i);
        enable_i = 1'b0;
        op_i = 2'h0;
        digit_count_operand_i = 16'h0004;
        start_i = 1'b1;
        @(negedge mclk_i);
        start_i = 1'b0;
        check_bit(busy_o, 1'b0);
        @(negedge mclk_i);
        enable_i = 1'b1;
        op_i = 2'h3;
        start_i = 1'b1;
        @(negedge mclk_i);
        start_i = 1'b0;
        check_bit(busy_o, 1'b0);
        repeat (6) @(negedge mclk_i);
        check_word(16'(mdl.wr_count - wr_base), 16'h0000);
        check_bit(program_error_flag_o, 1'b1);
        src_is_bit_i = 1'b1;
        dst_is_bit_i = 1'b1;
        src_is_timer_i = 1'b1;
        @(negedge mclk_i);
        check_bit(src_bit_mode_o, 1'b1);
        check_bit(dst_bit_mode_o, 1'b1);
        run(2'h0, 16'h1234, 16'h0001, 1'b0, 2, 1);
        check_word(mdl.dst_mem[0], 16'h0034);
        check_bit(mdl.preset_seen, 1'b0);
        $display("enable and operand mode done");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        report_and_stop;
    end
    initial begin
        repeat (16) @(negedge mclk_i);
        reset_n_i = 1'b1;
        @(negedge mclk_i);
        t_hex;
        t_bcd;
        t_ascii_to_hex_op;
        t_bad;
        t_enable_low;
        report_and_stop;
    end
endmodule
